// ---- rtl/pfp_pkg.sv ----
// pfp_pkg: shared constants and types of the program flash protection guard
// assumes: byte offsets on a 32-bit AHB-Lite register bus, 18-bit flash global addresses
package pfp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map, byte offsets inside the block's window
  localparam logic [7:0] PROT_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] MASK_OFS = 8'h10;
  localparam logic [7:0] LOAD_OFS = 8'h14;

  ////////////////////////////////////////////////////////////////////////////////
  // protection register fields
  localparam int POL_BIT = 7;
  localparam int RNV_BIT = 6;
  localparam int HDIS_BIT = 5;
  localparam int HS_LSB = 3;
  localparam int LDIS_BIT = 2;
  localparam int LS_LSB = 0;

  // value before the load and after a double-bit fault: polarity 0, rest 1
  localparam logic [7:0] PROT_RST_VAL = 8'h7F;
  localparam logic [7:0] PROT_FAULT_VAL = 8'h7F;

  // configuration byte location in the array
  localparam logic [17:0] CFG_PROT_ADDR = 18'h3FF0C;

  ////////////////////////////////////////////////////////////////////////////////
  // address geometry, 19 bits so the end of flash fits
  localparam logic [18:0] PF_END = 19'h40000;
  localparam logic [18:0] PF_SIZE = 19'h20000;
  localparam logic [18:0] LO_BASE = 19'h38000;
  localparam logic [18:0] HI_UNIT = 19'h00800;
  localparam logic [18:0] LO_UNIT = 19'h00400;

  ////////////////////////////////////////////////////////////////////////////////
  // event status bits
  localparam int EV_VIOL = 0;
  localparam int EV_BLK = 1;
  localparam int EV_SHRINK = 2;
  localparam int EV_FAULT = 3;
  localparam logic [3:0] EV_NONE = 4'h0;

  // reset-load sequencer
  typedef enum logic [1:0] {
    PFP_LD_REQ = 2'b00,
    PFP_LD_WAIT = 2'b01,
    PFP_LD_DONE = 2'b10
  } pfp_ld_e;

  // commands seen from the sequencer
  typedef enum logic [1:0] {
    PFP_CMD_PROG = 2'b00,
    PFP_CMD_SECT = 2'b01,
    PFP_CMD_BLK = 2'b10,
    PFP_CMD_BAD = 2'b11
  } pfp_cmd_e;

endpackage

// ---- rtl/pfp_prot_if.sv ----
// pfp_prot_if: a protection value and an address going to the range calculator
// assumes: purely combinational use inside the guard
`timescale 1ns/1ps
`default_nettype none
interface pfp_prot_if;
  logic [7:0] prot;
  logic [17:0] addr;
  logic hit;
  logic in_hi;
  logic in_lo;
  logic [18:0] size;
  modport user (output prot, output addr, input hit, input in_hi, input in_lo, input size);
  modport calc (input prot, input addr, output hit, output in_hi, output in_lo, output size);
endinterface
`default_nettype wire

// ---- rtl/pfp_range_calc.sv ----
// pfp_range_calc: decodes a protection value into a hit for one address and a protected size
// assumes: addresses lie inside program flash; high and low ranges never overlap
`timescale 1ns/1ps
`default_nettype none
module pfp_range_calc
  import pfp_pkg::*;
(
  pfp_prot_if.calc p
);

  logic [18:0] hi_len;
  logic [18:0] lo_len;
  logic [18:0] sel_len;
  logic [18:0] addr_w;
  logic hsel;
  logic lsel;

  ////////////////////////////////////////////////////////////////////////////////
  // range decode and protected size
  always_comb begin
    addr_w = {1'b0, p.addr};
    hi_len = HI_UNIT << p.prot[HS_LSB +: 2]; // R10
    lo_len = LO_UNIT << p.prot[LS_LSB +: 2]; // R11
    hsel = !p.prot[HDIS_BIT];
    lsel = !p.prot[LDIS_BIT];
    p.in_hi = addr_w >= (PF_END - hi_len); // R10
    p.in_lo = (addr_w >= LO_BASE) && (addr_w < (LO_BASE + lo_len)); // R11
    sel_len = (hsel ? hi_len : 19'h00000) + (lsel ? lo_len : 19'h00000);
    if (p.prot[POL_BIT]) begin
      p.hit = (hsel && p.in_hi) || (lsel && p.in_lo); // R7
      p.size = sel_len; // R7
    end else begin
      p.hit = !((hsel && p.in_hi) || (lsel && p.in_lo)); // R6
      p.size = PF_SIZE - sel_len; // R13
    end
  end

endmodule // pfp_range_calc
`default_nettype wire

// ---- rtl/pfp_guard.sv ----
// pfp_guard: program flash protection register, reset load and command guard
// assumes: one AHB-Lite master, a flash read port that answers the reset load,
// and a command sequencer on the same clock that offers each program or erase once
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: software writes succeed only if the protected region does not shrink.
// R2: at reset the register loads from the configuration byte at 0x3_FF0C.
// R3: a double-bit fault on that load leaves all flash protected.
// R4: program or erase into a protected area is refused and flags a violation.
// R5: block erase is refused while any sector of the block is protected.
// R6: polarity 0 makes the disable bits select unprotected ranges.
// R7: polarity 1 makes the disable bits select protected ranges.
// R8: software keeps the reserved nonvolatile bit 6 erased.
// R9: software unprotects the top sector before reprogramming the stored byte.
// R10: high size field picks 2, 4, 8 or 16 KB ending at flash top.
// R11: low size field picks 1, 2, 4 or 8 KB from the low boundary.
// R12: a size field changes only while its range disable bit is set.
// R13: polarity 0 with both disables set protects all; all three set protect nothing.
// R14: a shrinking write leaves the whole register unchanged.
module pfp_guard
  import pfp_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic cfg_rd_req,
  output logic [17:0] cfg_rd_addr,
  input wire logic cfg_rd_valid,
  input wire logic [7:0] cfg_rd_data,
  input wire logic cfg_rd_dbl_fault,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [17:0] cmd_addr,
  output logic cmd_done,
  output logic cmd_refused,
  output logic [7:0] prot_value,
  output logic irq
);

  pfp_ld_e ld_r, ld_nxt;
  logic [7:0] prot_r, prot_nxt;
  logic fault_seen_r, fault_seen_nxt;
  logic cfg_req_r, cfg_req_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_ofs_r, wr_ofs_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic hreadyout_r;
  logic hresp_r;
  logic cmd_done_r, cmd_done_nxt;
  logic cmd_ref_r, cmd_ref_nxt;
  logic [3:0] stat_r, stat_nxt;
  logic [3:0] mask_r, mask_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] cand;
  logic acc_ph;
  logic rd_go;
  logic any_prot;
  logic prot_wr;
  logic viol_ev;
  logic blk_ev;
  logic shrink_ev;
  logic fault_ev;

  pfp_prot_if cur_if ();
  pfp_prot_if new_if ();

  ////////////////////////////////////////////////////////////////////////////////
  // range calculators: live value against the command address, candidate for its size
  assign cur_if.prot = prot_r;
  assign cur_if.addr = cmd_addr;
  assign new_if.prot = cand;
  assign new_if.addr = cmd_addr;

  pfp_range_calc u_cur_calc (
    .p(cur_if)
  );

  pfp_range_calc u_new_calc (
    .p(new_if)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bus: zero-wait slave, read data captured in the address phase
  assign acc_ph = hsel && htrans[1] && hready;
  assign rd_go = acc_ph && !hwrite;
  assign prot_wr = wr_pend_r && (wr_ofs_r == PROT_OFS);

  always_comb begin
    wr_pend_nxt = acc_ph && hwrite;
    wr_ofs_nxt = acc_ph ? haddr[7:0] : wr_ofs_r;
    hrdata_nxt = hrdata_r;
    if (rd_go) begin
      unique case (haddr[7:0])
        PROT_OFS: hrdata_nxt = {24'h000000, prot_r};
        STAT_OFS: hrdata_nxt = {28'h0000000, stat_r};
        MASK_OFS: hrdata_nxt = {28'h0000000, mask_r};
        LOAD_OFS: hrdata_nxt = {30'h0000000, fault_seen_r, ld_r == PFP_LD_DONE};
        default: hrdata_nxt = 32'h00000000; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_ofs_r <= wr_ofs_nxt;
      hrdata_r <= hrdata_nxt;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // candidate value of a software write to the protection register
  always_comb begin
    cand = prot_r;
    cand[POL_BIT] = hwdata[POL_BIT];
    cand[RNV_BIT] = prot_r[RNV_BIT]; // R8
    cand[HDIS_BIT] = hwdata[HDIS_BIT];
    cand[LDIS_BIT] = hwdata[LDIS_BIT];
    if (prot_r[HDIS_BIT]) begin
      cand[HS_LSB +: 2] = hwdata[HS_LSB +: 2]; // R12
    end
    if (prot_r[LDIS_BIT]) begin
      cand[LS_LSB +: 2] = hwdata[LS_LSB +: 2]; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset load and protection register
  always_comb begin
    ld_nxt = ld_r;
    prot_nxt = prot_r;
    fault_seen_nxt = fault_seen_r;
    cfg_req_nxt = 1'b0;
    fault_ev = 1'b0;
    shrink_ev = 1'b0;
    unique case (ld_r)
      PFP_LD_REQ: begin
        cfg_req_nxt = 1'b1; // R2
        ld_nxt = PFP_LD_WAIT;
      end
      PFP_LD_WAIT: begin
        if (cfg_rd_valid) begin
          ld_nxt = PFP_LD_DONE;
          if (cfg_rd_dbl_fault) begin
            prot_nxt = PROT_FAULT_VAL; // R3
            fault_seen_nxt = 1'b1;
            fault_ev = 1'b1;
          end else begin
            prot_nxt = cfg_rd_data; // R2
          end
        end
      end
      PFP_LD_DONE: begin
        if (prot_wr) begin
          if (new_if.size >= cur_if.size) begin
            prot_nxt = cand; // R1
          end else begin
            shrink_ev = 1'b1; // R14
          end
        end
      end
      default: ld_nxt = PFP_LD_REQ;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ld_r <= PFP_LD_REQ;
      prot_r <= PROT_RST_VAL;
      fault_seen_r <= 1'b0;
      cfg_req_r <= 1'b0;
    end else begin
      ld_r <= ld_nxt;
      prot_r <= prot_nxt;
      fault_seen_r <= fault_seen_nxt;
      cfg_req_r <= cfg_req_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command guard: answer one cycle after each offered command
  assign any_prot = !(prot_r[POL_BIT] && prot_r[HDIS_BIT] && prot_r[LDIS_BIT]); // R13

  always_comb begin
    cmd_done_nxt = cmd_valid;
    cmd_ref_nxt = 1'b0;
    viol_ev = 1'b0;
    blk_ev = 1'b0;
    if (cmd_valid) begin
      if (ld_r != PFP_LD_DONE) begin
        cmd_ref_nxt = 1'b1; // nothing may change before protection is known
      end else begin
        unique case (cmd_kind)
          PFP_CMD_PROG, PFP_CMD_SECT: begin
            cmd_ref_nxt = cur_if.hit; // R4
            viol_ev = cur_if.hit; // R4
          end
          PFP_CMD_BLK: begin
            cmd_ref_nxt = any_prot; // R5
            viol_ev = any_prot; // R4
            blk_ev = any_prot; // R5
          end
          PFP_CMD_BAD: cmd_ref_nxt = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_done_r <= 1'b0;
      cmd_ref_r <= 1'b0;
    end else begin
      cmd_done_r <= cmd_done_nxt;
      cmd_ref_r <= cmd_ref_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event status, mask and interrupt; a new event beats the read-clear
  always_comb begin
    stat_nxt = stat_r;
    if (rd_go && (haddr[7:0] == STAT_OFS)) begin
      stat_nxt = EV_NONE;
    end
    stat_nxt[EV_VIOL] = stat_nxt[EV_VIOL] | viol_ev; // R4
    stat_nxt[EV_BLK] = stat_nxt[EV_BLK] | blk_ev;
    stat_nxt[EV_SHRINK] = stat_nxt[EV_SHRINK] | shrink_ev;
    stat_nxt[EV_FAULT] = stat_nxt[EV_FAULT] | fault_ev;
    mask_nxt = (wr_pend_r && (wr_ofs_r == MASK_OFS)) ? hwdata[3:0] : mask_r;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stat_r <= EV_NONE;
      mask_r <= EV_NONE;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign cfg_rd_req = cfg_req_r;
  assign cfg_rd_addr = CFG_PROT_ADDR;
  assign cmd_done = cmd_done_r;
  assign cmd_refused = cmd_ref_r;
  assign prot_value = prot_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_no_shrink: assert property ( // R1
    (ld_r == PFP_LD_DONE) && prot_wr |=> (cur_if.size >= $past(cur_if.size)))
    else $error("protected region shrank after a write");

  a_load_value: assert property ( // R2
    (ld_r == PFP_LD_WAIT) && cfg_rd_valid && !cfg_rd_dbl_fault |=> (prot_r == $past(cfg_rd_data)))
    else $error("protection byte not loaded at reset");

  a_fault_full: assert property ( // R3
    (ld_r == PFP_LD_WAIT) && cfg_rd_valid && cfg_rd_dbl_fault
      |=> (prot_r == PROT_FAULT_VAL) && stat_r[EV_FAULT] ##1 (ld_r == PFP_LD_DONE))
    else $error("double-bit fault did not protect all flash");

  a_viol_flag: assert property ( // R4
    cmd_valid && (ld_r == PFP_LD_DONE) && cur_if.hit
      && ((cmd_kind == PFP_CMD_PROG) || (cmd_kind == PFP_CMD_SECT))
      |=> cmd_done && cmd_refused && stat_r[EV_VIOL])
    else $error("protected program or erase not refused");

  a_blk_refuse: assert property ( // R5
    cmd_valid && (cmd_kind == PFP_CMD_BLK) && any_prot |=> cmd_refused && cmd_done)
    else $error("block erase allowed while protected");

  a_pol_ranges: assert property ( // R6
    !prot_r[POL_BIT] && !prot_r[HDIS_BIT] && cur_if.in_hi |-> !cur_if.hit)
    else $error("polarity 0 high range not unprotected");

  a_pol_protect: assert property ( // R7
    prot_r[POL_BIT] && !prot_r[LDIS_BIT] && cur_if.in_lo |-> cur_if.hit)
    else $error("polarity 1 low range not protected");

  a_size_lock: assert property ( // R12
    (ld_r == PFP_LD_DONE) ##1 (prot_r[HS_LSB +: 2] != $past(prot_r[HS_LSB +: 2]))
      |-> $past(prot_r[HDIS_BIT]))
    else $error("high size field changed while range enabled");

  a_full_prot: assert property ( // R13
    !prot_r[POL_BIT] && prot_r[HDIS_BIT] && prot_r[LDIS_BIT] |-> cur_if.hit)
    else $error("full protection setting left an address open");

  a_irq_level: assert property (
    irq == |(stat_r & mask_r))
    else $error("interrupt does not follow masked status");

endmodule // pfp_guard
`default_nettype wire

// ---- dv/pfp_guard_test.sv ----
// pfp_guard_test: self-checking bench for the program flash protection guard
// assumes: the guard is the only AHB-Lite slave; the bench plays flash read port and command sequencer
`timescale 1ns/1ps
`default_nettype none
module pfp_guard_test
  import pfp_pkg::*;
;
  logic mclk, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, cmd_kind;
  logic [2:0] hsize;
  logic cfg_rd_req, cfg_rd_valid, cfg_rd_dbl_fault, cmd_valid, cmd_done, cmd_refused, irq;
  logic [17:0] cfg_rd_addr, cmd_addr;
  logic [7:0] cfg_rd_data, prot_value;
  int num_errors = 0;
  int total_checks = 0;

  assign hready = hreadyout;

  pfp_guard dut_u (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cfg_rd_req(cfg_rd_req), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data),
    .cfg_rd_dbl_fault(cfg_rd_dbl_fault), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_done(cmd_done), .cmd_refused(cmd_refused), .prot_value(prot_value), .irq(irq));

  //////////////////////////////////////////////////////////////////////////////
  // clock, 40 ns period
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // verdict and comparison
  task test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // bus master: entered and left right after a rising edge
  task xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, ofs};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask

  task wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, ofs, d, x);
  endtask

  task rd_chk(input logic [7:0] ofs, input logic [31:0] exp, input string what);
    logic [31:0] x;
    xfer(1'b0, ofs, 32'h0000_0000, x);
    chk(what, exp, x);
  endtask

  // level outputs are looked at mid-cycle, then back to a rising edge
  task pchk(input logic [7:0] exp);
    @(negedge mclk);
    chk("prot_value", {24'h00_0000, exp}, {24'h00_0000, prot_value});
    @(posedge mclk);
  endtask

  task irq_chk(input logic exp);
    @(negedge mclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
    @(posedge mclk);
  endtask

  // one command, answered by a one-cycle done one cycle later
  task cmd(input pfp_cmd_e k, input logic [17:0] a, input logic exp);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    @(negedge mclk);
    chk("cmd_done", 32'h0000_0001, {31'h0, cmd_done});
    chk("cmd_refused", {31'h0, exp}, {31'h0, cmd_refused});
    @(posedge mclk);
  endtask

  // reset, then answer the configuration fetch; a command before the load is refused
  task do_reset(input logic [7:0] ld, input logic flt);
    int n;
    rstn <= 1'b0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (cfg_rd_req !== 1'b1 && n < 50);
    chk("cfg_rd_req", 32'h0000_0001, {31'h0, cfg_rd_req});
    chk("cfg_rd_addr", {14'h0000, CFG_PROT_ADDR}, {14'h0000, cfg_rd_addr});
    chk("prot_value", {24'h00_0000, PROT_RST_VAL}, {24'h00_0000, prot_value});
    @(posedge mclk);
    cmd(PFP_CMD_PROG, 18'h3_F800, 1'b1);
    cfg_rd_valid <= 1'b1;
    cfg_rd_data <= ld;
    cfg_rd_dbl_fault <= flt;
    @(posedge mclk);
    cfg_rd_valid <= 1'b0;
    cfg_rd_dbl_fault <= 1'b0;
    @(posedge mclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_load_open;
    do_reset(8'hA4, 1'b0);
    pchk(8'hA4);
    rd_chk(PROT_OFS, 32'h0000_00A4, "prot reg");
    rd_chk(LOAD_OFS, 32'h0000_0001, "load status");
    wr(PROT_OFS, 32'h0000_00A4);
    pchk(8'hA4);
    cmd(PFP_CMD_PROG, 18'h3_FFFF, 1'b0);
    cmd(PFP_CMD_BLK, 18'h2_0000, 1'b0);
    cmd(PFP_CMD_BAD, 18'h2_0000, 1'b1);
    rd_chk(STAT_OFS, 32'h0000_0000, "status bad kind");
  endtask

  task t_grow_high;
    wr(PROT_OFS, 32'h0000_009C);
    pchk(8'h9C);
    cmd(PFP_CMD_PROG, 18'h3_C000, 1'b1);
    cmd(PFP_CMD_SECT, 18'h3_BFFF, 1'b0);
    cmd(PFP_CMD_BLK, 18'h2_0000, 1'b1);
    irq_chk(1'b0);
    rd_chk(STAT_OFS, 32'h0000_0003, "status viol blk");
    rd_chk(STAT_OFS, 32'h0000_0000, "status cleared");
  endtask

  task t_shrink;
    wr(PROT_OFS, 32'h0000_00BC);
    pchk(8'h9C);
    rd_chk(STAT_OFS, 32'h0000_0004, "status shrink");
  endtask

  task t_size_lock;
    wr(PROT_OFS, 32'h0000_0083);
    pchk(8'h9B);
    cmd(PFP_CMD_PROG, 18'h3_8000, 1'b1);
    cmd(PFP_CMD_SECT, 18'h3_9FFF, 1'b1);
    cmd(PFP_CMD_PROG, 18'h3_A000, 1'b0);
    rd_chk(STAT_OFS, 32'h0000_0001, "status low range");
  endtask

  task t_full_irq;
    wr(MASK_OFS, 32'h0000_000F);
    rd_chk(MASK_OFS, 32'h0000_000F, "mask reg");
    wr(PROT_OFS, 32'h0000_007F);
    pchk(8'h3F);
    cmd(PFP_CMD_PROG, 18'h2_0000, 1'b1);
    irq_chk(1'b1);
    rd_chk(STAT_OFS, 32'h0000_0001, "status full");
    repeat (2) @(posedge mclk);
    irq_chk(1'b0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd_chk(8'h20, 32'h0000_0000, "unmapped");
  endtask

  task t_unprot_ranges;
    do_reset(8'h1B, 1'b0);
    pchk(8'h1B);
    cmd(PFP_CMD_PROG, 18'h3_C000, 1'b0);
    cmd(PFP_CMD_PROG, 18'h3_BFFF, 1'b1);
    cmd(PFP_CMD_SECT, 18'h3_8000, 1'b0);
    cmd(PFP_CMD_SECT, 18'h3_A000, 1'b1);
    cmd(PFP_CMD_PROG, CFG_PROT_ADDR, 1'b0);
    cmd(PFP_CMD_BLK, 18'h2_0000, 1'b1);
  endtask

  task t_fault;
    do_reset(8'hA4, 1'b1);
    pchk(PROT_FAULT_VAL);
    rd_chk(LOAD_OFS, 32'h0000_0003, "load status fault");
    rd_chk(STAT_OFS, 32'h0000_0008, "status fault");
    cmd(PFP_CMD_PROG, 18'h3_FFFF, 1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    cfg_rd_valid = 1'b0;
    cfg_rd_data = 8'h00;
    cfg_rd_dbl_fault = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = 2'b00;
    cmd_addr = 18'h2_0000;
    @(posedge mclk);
    t_load_open();
    t_grow_high();
    t_shrink();
    t_size_lock();
    t_full_irq();
    t_unprot_ranges();
    t_fault();
    test_done();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    test_done();
  end
endmodule // pfp_guard_test
`default_nettype wire
